// [directional_earth_fault_stage_logic.sv]
// two-stage directional neutral overcurrent decision logic with AXI4-Lite settings
`timescale 1ns/1ps
// Overview of operation
// R1: stage starts only while current component and residual voltage both exceed thresholds
// R2: start held for operate time also raises that stage's trip
// R3: indicator shows yellow on start and turns red on trip
// R4: indicators self-reset or manual; manual cleared by reset button or command a/b
// R5: active low-stage block suppresses low-set tripping
// R6: active high-stage block suppresses high-set tripping
// R7: board switches route external block inputs onto the two stage blocks
// R8: board switches choose which starts drive the reclose initiation outputs
// R9: front bit 1 sets high-set direction; low-set works forward only
// R10: front bits 7 and 8 pick one of four voltage thresholds
// R11: with front bit 2 clear, front bit 3 picks active or reactive component
// R12: with front bit 2 set, the external characteristic input decides instead
// R13: external input 0 picks reactive, 1 picks active component
// R14: front bit 5 picks the low-set operate time range
// R15: front bit 6 picks high-set threshold range 5..40% or 1..8%
// R16: infinite high-set threshold disables that stage completely
// R17: with latching on, trip stays after its cause has gone
// R18: latched trips clear on step plus reset buttons or command a/b
// R19: indicator function switches hold self or manual reset per indicator
// R20: front bit 5 clear gives short range, set gives tenfold range
// R21: manual start indicator stays lit after stage recovers until reset
// R22: indicators never influence start or trip behaviour
// R23: operate timer restarts from zero when start drops early
// R24: without latching, trip drops as soon as start drops
module directional_earth_fault_stage_logic
	import def_stage_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_BASE_CYCLES
)
(
	input  wire logic               clk_sys,
	input  wire logic               reset,
	input  wire logic        [31:0] s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic        [31:0] s_axi_wdata,
	input  wire logic        [3:0]  s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic             [1:0]  s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic        [31:0] s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic             [31:0] s_axi_rdata,
	output logic             [1:0]  s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic signed [15:0] activeCurrent,
	input  wire logic signed [15:0] reactiveCurrent,
	input  wire logic        [15:0] residualVoltage,
	input  wire logic        [2:0]  external_block_inputs,
	input  wire logic               characteristic_select_in,
	input  wire logic               resetButton,
	input  wire logic               stepButton,
	output stage_out_t              lowStage,
	output stage_out_t              highStage,
	output indicator_t              lowIndicator,
	output indicator_t              highIndicator,
	output logic             [1:0]  reclose_initiation_outputs
);

	logic [7:0]  front_switch_bank_r;
	logic [3:0]  indicator_function_switches_r;
	logic [9:0]  board_config_switches_r;
	logic [15:0] lowStartThr_r;
	logic [15:0] lowTime_r;
	logic [15:0] highStartThr_r;
	logic [15:0] highTime_r;

	logic [7:0]  awAddr_r;
	logic        awHeld_r;
	logic [31:0] wData_r;
	logic [3:0]  wStrb_r;
	logic        wHeld_r;
	logic        doWrite;
	logic        writeMapped;
	logic [7:0]  rdAddr;
	logic [31:0] rdValue;
	logic        rdMapped;
	logic        cmdResetA;
	logic        cmdResetB;

	logic [31:0] baseCount_r;
	logic        baseTick;
	logic [3:0]  decade_r;
	logic        longTick;
	logic        lowTick;

	logic               useCosine;
	logic signed [15:0] component;
	logic        [15:0] uRef;
	logic               voltageOk;
	logic        [15:0] highThr;
	logic               highDisabled;
	logic               lowStartCond;
	logic               highStartCond;
	logic               low_stage_block;
	logic               high_stage_block;
	logic               low_stage_trip;
	logic               high_stage_trip;
	logic               indClear;
	logic               latchClear;
	logic [3:0]         indMem_r;
	logic [3:0]         indLive;
	logic [3:0]         indLit;

	// true when the signed measured value lies strictly above an unsigned threshold
	function automatic logic exceeds(input logic signed [15:0] value, input logic [15:0] thr);
		logic signed [17:0] v;
		logic signed [17:0] t;
		v = {{2{value[15]}}, value};
		t = {2'b00, thr};
		exceeds = (v > t);
	endfunction

	// merges the byte lanes that the write strobe enables into an old register value
	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		end
		mergeBytes = res;
	endfunction

	// write path: address and data are accepted in either order, answered once both are held
	assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
	assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
	assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

	always_comb
	begin
		case (awAddr_r)
			ADDR_FRONT_SW, ADDR_IND_SW, ADDR_BOARD_SW, ADDR_LOW_START, ADDR_LOW_TIME,
			ADDR_HIGH_START, ADDR_HIGH_TIME, ADDR_COMMAND: writeMapped = 1'b1;
			default: writeMapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			awHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			awHeld_r <= 1'b1;
			awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
		end
		else if (doWrite)
			awHeld_r <= 1'b0;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			wHeld_r <= 1'b0;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			wHeld_r <= 1'b1;
			wData_r <= s_axi_wdata;
			wStrb_r <= s_axi_wstrb;
		end
		else if (doWrite)
			wHeld_r <= 1'b0;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (doWrite)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= writeMapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			front_switch_bank_r <= FRONT_SW_RESET;
			indicator_function_switches_r <= IND_SW_RESET;
			board_config_switches_r <= BOARD_SW_RESET;
			lowStartThr_r <= LOW_START_RESET;
			lowTime_r <= LOW_TIME_RESET;
			highStartThr_r <= HIGH_START_RESET;
			highTime_r <= HIGH_TIME_RESET;
		end
		else if (doWrite)
		begin
			case (awAddr_r)
				ADDR_FRONT_SW: front_switch_bank_r <=
					8'(mergeBytes({24'h000000, front_switch_bank_r}, wData_r, wStrb_r));
				ADDR_IND_SW: indicator_function_switches_r <=
					4'(mergeBytes({28'h0000000, indicator_function_switches_r}, wData_r, wStrb_r));
				ADDR_BOARD_SW: board_config_switches_r <=
					10'(mergeBytes({22'h000000, board_config_switches_r}, wData_r, wStrb_r));
				ADDR_LOW_START: lowStartThr_r <=
					16'(mergeBytes({16'h0000, lowStartThr_r}, wData_r, wStrb_r));
				ADDR_LOW_TIME: lowTime_r <= 16'(mergeBytes({16'h0000, lowTime_r}, wData_r, wStrb_r));
				ADDR_HIGH_START: highStartThr_r <=
					16'(mergeBytes({16'h0000, highStartThr_r}, wData_r, wStrb_r));
				ADDR_HIGH_TIME: highTime_r <=
					16'(mergeBytes({16'h0000, highTime_r}, wData_r, wStrb_r));
				default: ;
			endcase
		end
	end

	// serial indicator-reset commands are one-cycle pulses; the command word itself is not stored
	assign cmdResetA = doWrite && (awAddr_r == ADDR_COMMAND) && wStrb_r[0]
		&& wData_r[CMD_IND_RESET_A];
	assign cmdResetB = doWrite && (awAddr_r == ADDR_COMMAND) && wStrb_r[0]
		&& wData_r[CMD_IND_RESET_B];

	// read path: one read at a time, data one cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;
	assign rdAddr = {s_axi_araddr[7:2], 2'b00};

	always_comb
	begin
		rdMapped = 1'b1;
		case (rdAddr)
			ADDR_FRONT_SW: rdValue = {24'h000000, front_switch_bank_r};
			ADDR_IND_SW: rdValue = {28'h0000000, indicator_function_switches_r};
			ADDR_BOARD_SW: rdValue = {22'h000000, board_config_switches_r};
			ADDR_LOW_START: rdValue = {16'h0000, lowStartThr_r};
			ADDR_LOW_TIME: rdValue = {16'h0000, lowTime_r};
			ADDR_HIGH_START: rdValue = {16'h0000, highStartThr_r};
			ADDR_HIGH_TIME: rdValue = {16'h0000, highTime_r};
			ADDR_COMMAND: rdValue = 32'h00000000;
			ADDR_STATUS: rdValue = {22'h000000, reclose_initiation_outputs,
				lowIndicator, highIndicator, lowStage, highStage};
			default:
			begin
				rdValue = 32'h00000000;
				rdMapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdValue;
			s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// time base: one base tick, and a tenfold slower tick for the long low-set range
	assign baseTick = (baseCount_r == 32'(TICK_CYCLES - 1));
	assign longTick = baseTick && (decade_r == LONG_RANGE_FACTOR - 4'h1);
	assign lowTick = front_switch_bank_r[FSW_LOW_LONG] ? longTick : baseTick; // [R14] [R20]

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			baseCount_r <= 32'h00000000;
		else if (baseTick)
			baseCount_r <= 32'h00000000;
		else
			baseCount_r <= baseCount_r + 32'h00000001;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			decade_r <= 4'h0;
		else if (longTick)
			decade_r <= 4'h0;
		else if (baseTick)
			decade_r <= decade_r + 4'h1;
	end

	// characteristic choice: local switch unless remote control is selected
	always_comb
	begin
		if (front_switch_bank_r[FSW_REMOTE_CHAR])
			useCosine = characteristic_select_in; // [R12] [R13]
		else
			useCosine = front_switch_bank_r[FSW_LOCAL_COSINE]; // [R11]
		component = useCosine ? activeCurrent : reactiveCurrent;
	end

	always_comb
	begin
		case (front_switch_bank_r[FSW_UREF_HI:FSW_UREF_LO]) // [R10]
			2'h0: uRef = UREF_0;
			2'h1: uRef = UREF_1;
			2'h2: uRef = UREF_2;
			default: uRef = UREF_3;
		endcase
	end

	assign voltageOk = (residualVoltage > uRef);
	// fine range maps the same setting codes to one fifth of their value, 5..40 onto 1..8
	assign highThr = front_switch_bank_r[FSW_HIGH_FINE]
		? highStartThr_r / {13'h0000, FINE_RANGE_DIVISOR} : highStartThr_r; // [R15]
	assign highDisabled = (highStartThr_r == THRESHOLD_INFINITE); // [R16]

	assign lowStartCond = exceeds(component, lowStartThr_r) && voltageOk; // [R1] [R9]
	assign highStartCond = !highDisabled && voltageOk
		&& (front_switch_bank_r[FSW_HIGH_REVERSE]
			? exceeds(16'(-component), highThr) : exceeds(component, highThr)); // [R1] [R9] [R16]

	assign low_stage_block = |(external_block_inputs
		& board_config_switches_r[BSW_LOW_BLOCK +: 3]); // [R7]
	assign high_stage_block = |(external_block_inputs
		& board_config_switches_r[BSW_HIGH_BLOCK +: 3]); // [R7]

	assign latchClear = (stepButton && resetButton) || cmdResetA || cmdResetB; // [R18]
	assign indClear = resetButton || cmdResetA || cmdResetB; // [R4]

	stage_timer lowTimer
	(
		.clk_sys     (clk_sys),
		.reset       (reset),
		.tickPulse   (lowTick),
		.startCond   (lowStartCond),
		.block       (low_stage_block), // [R5]
		.latchEn     (front_switch_bank_r[FSW_LATCH]),
		.latchClear  (latchClear),
		.timeSetting (lowTime_r),
		.trip        (low_stage_trip)
	);

	stage_timer highTimer
	(
		.clk_sys     (clk_sys),
		.reset       (reset),
		.tickPulse   (baseTick),
		.startCond   (highStartCond),
		.block       (high_stage_block), // [R6]
		.latchEn     (front_switch_bank_r[FSW_LATCH]),
		.latchClear  (latchClear),
		.timeSetting (highTime_r),
		.trip        (high_stage_trip)
	);

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			lowStage <= '0;
			highStage <= '0;
		end
		else
		begin
			lowStage <= '{start: lowStartCond, trip: low_stage_trip}; // [R1] [R2]
			highStage <= '{start: highStartCond, trip: high_stage_trip}; // [R1] [R2]
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			reclose_initiation_outputs <= 2'b00;
		else
		begin
			reclose_initiation_outputs[0] <=
				(board_config_switches_r[BSW_RI0_LOW] && lowStartCond)
				|| (board_config_switches_r[BSW_RI0_HIGH] && highStartCond); // [R8]
			reclose_initiation_outputs[1] <=
				(board_config_switches_r[BSW_RI1_LOW] && lowStartCond)
				|| (board_config_switches_r[BSW_RI1_HIGH] && highStartCond); // [R8]
		end
	end

	// indicator order: low start, low trip, high start, high trip, as in the function switches
	assign indLive = {high_stage_trip, highStartCond, low_stage_trip, lowStartCond};

	// memory only matters for manual indicators; a new event wins over a clear in the same cycle
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			indMem_r <= 4'h0;
		else
			indMem_r <= indLive | (indMem_r & {4{!indClear}}); // [R4] [R21]
	end

	assign indLit = (indicator_function_switches_r & indMem_r)
		| (~indicator_function_switches_r & indLive); // [R19]

	// indicators are outputs only; nothing here feeds back into the stage decisions
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			lowIndicator <= '0;
			highIndicator <= '0;
		end
		else
		begin
			lowIndicator <= '{yellow: indLit[ISW_LOW_START] && !indLit[ISW_LOW_TRIP],
				red: indLit[ISW_LOW_TRIP]}; // [R3] [R22]
			highIndicator <= '{yellow: indLit[ISW_HIGH_START] && !indLit[ISW_HIGH_TRIP],
				red: indLit[ISW_HIGH_TRIP]}; // [R3] [R22]
		end
	end

endmodule // directional_earth_fault_stage_logic

// [def_stage_pkg.sv]
// shared constants, register map and carrier types of the earth-fault stage logic
package def_stage_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_BASE_NS = 10_000_000;
	localparam int TICK_BASE_CYCLES = TICK_BASE_NS / CLK_PERIOD_NS;
	localparam logic [3:0] LONG_RANGE_FACTOR = 4'hA;

	localparam logic [7:0] ADDR_FRONT_SW = 8'h00;
	localparam logic [7:0] ADDR_IND_SW = 8'h04;
	localparam logic [7:0] ADDR_BOARD_SW = 8'h08;
	localparam logic [7:0] ADDR_LOW_START = 8'h0C;
	localparam logic [7:0] ADDR_LOW_TIME = 8'h10;
	localparam logic [7:0] ADDR_HIGH_START = 8'h14;
	localparam logic [7:0] ADDR_HIGH_TIME = 8'h18;
	localparam logic [7:0] ADDR_COMMAND = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;

	localparam int FSW_HIGH_REVERSE = 0;
	localparam int FSW_REMOTE_CHAR = 1;
	localparam int FSW_LOCAL_COSINE = 2;
	localparam int FSW_LATCH = 3;
	localparam int FSW_LOW_LONG = 4;
	localparam int FSW_HIGH_FINE = 5;
	localparam int FSW_UREF_LO = 6;
	localparam int FSW_UREF_HI = 7;

	localparam int ISW_LOW_START = 0;
	localparam int ISW_LOW_TRIP = 1;
	localparam int ISW_HIGH_START = 2;
	localparam int ISW_HIGH_TRIP = 3;

	localparam int BSW_LOW_BLOCK = 0;
	localparam int BSW_HIGH_BLOCK = 3;
	localparam int BSW_RI0_LOW = 6;
	localparam int BSW_RI0_HIGH = 7;
	localparam int BSW_RI1_LOW = 8;
	localparam int BSW_RI1_HIGH = 9;

	localparam int CMD_IND_RESET_A = 0;
	localparam int CMD_IND_RESET_B = 1;

	localparam logic [7:0] FRONT_SW_RESET = 8'h00;
	localparam logic [3:0] IND_SW_RESET = 4'h0;
	localparam logic [9:0] BOARD_SW_RESET = 10'h000;
	localparam logic [15:0] LOW_START_RESET = 16'h0064;
	localparam logic [15:0] LOW_TIME_RESET = 16'h000A;
	localparam logic [15:0] HIGH_START_RESET = 16'hFFFF;
	localparam logic [15:0] HIGH_TIME_RESET = 16'h000A;
	localparam logic [15:0] THRESHOLD_INFINITE = 16'hFFFF;
	localparam logic [2:0] FINE_RANGE_DIVISOR = 3'h5;

	localparam logic [15:0] UREF_0 = 16'h0100;
	localparam logic [15:0] UREF_1 = 16'h0200;
	localparam logic [15:0] UREF_2 = 16'h0400;
	localparam logic [15:0] UREF_3 = 16'h0800;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic start;
		logic trip;
	} stage_out_t;

	typedef struct packed {
		logic yellow;
		logic red;
	} indicator_t;

endpackage

// [stage_timer.sv]
// operate timer and trip latch of one protection stage
`timescale 1ns/1ps
module stage_timer
	import def_stage_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        tickPulse,
	input  wire logic        startCond,
	input  wire logic        block,
	input  wire logic        latchEn,
	input  wire logic        latchClear,
	input  wire logic [15:0] timeSetting,
	output logic             trip
);

	logic [15:0] ticks_r;
	logic        expired;
	logic        tripRaw;
	logic        latched_r;

	assign expired = (ticks_r >= timeSetting);
	assign tripRaw = startCond && expired && !block;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			ticks_r <= 16'h0000;
		else if (!startCond)
			ticks_r <= 16'h0000; // [R23]
		else if (tickPulse && !expired)
			ticks_r <= ticks_r + 16'h0001; // [R2]
	end

	// a new trip wins over a clear arriving in the same cycle
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			latched_r <= 1'b0;
		else
			latched_r <= (tripRaw && latchEn) || (latched_r && !latchClear); // [R17] [R18]
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			trip <= 1'b0;
		else
			trip <= tripRaw || latched_r; // [R24] [R5] [R6]
	end

endmodule // stage_timer

// [def_far_side_model.sv]
// far-side model: external blocking contacts feeding the stage logic
`timescale 1ns/1ps
module def_far_side_model
(
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [2:0] blockReq,
	output logic      [2:0] blockOut
);
	// contacts follow the request one clock late, as a real contact never answers at once
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			blockOut <= 3'h0;
		else
			blockOut <= blockReq;
	end
endmodule // def_far_side_model

// [def_stage_monitor.sv]
// concurrent checks on the ports of the earth-fault stage logic
`timescale 1ns/1ps
module def_stage_monitor
	import def_stage_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        resetButton,
	input stage_out_t       lowStage,
	input stage_out_t       highStage,
	input indicator_t       lowIndicator
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response left before acceptance");
	a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_write_stall: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_stall: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_low_trip_cause: assert property ($rose(lowStage.trip) |-> $past(lowStage.start))
		else $error("low trip rose without start");
	a_high_trip_cause: assert property ($rose(highStage.trip) |-> $past(highStage.start))
		else $error("high trip rose without start");
	a_red_on_trip: assert property (lowStage.trip |-> ##[0:2] lowIndicator.red)
		else $error("low indicator not red on trip");
	a_yellow_on_start: assert property ($rose(lowStage.start) |-> ##[0:2] |lowIndicator)
		else $error("low indicator dark on start");
	a_button_clears: assert property ((resetButton && !lowStage)[*3] |-> !lowIndicator)
		else $error("low indicator kept through reset button");
endmodule // def_stage_monitor

bind directional_earth_fault_stage_logic def_stage_monitor def_stage_monitor_i (.*);

// [directional_earth_fault_stage_logic_test.sv]
// self-checking bench for the earth-fault stage logic
`timescale 1ns/1ps
module directional_earth_fault_stage_logic_test;
	import def_stage_pkg::*;
	logic        clk_sys, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, characteristic_select_in, resetButton, stepButton;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, lfsr, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, reclose_initiation_outputs, rsp, e;
	logic [15:0] activeCurrent, reactiveCurrent, residualVoltage;
	logic [2:0]  external_block_inputs, blockReq;
	logic [7:0]  fsw;
	logic [9:0]  bsw;
	stage_out_t  lowStage, highStage;
	indicator_t  lowIndicator, highIndicator;
	int          num_errors, cmp_count, n, a, r, v;
	logic [7:0]  adrTab [4] = '{ADDR_LOW_START, ADDR_LOW_TIME, ADDR_HIGH_START, ADDR_HIGH_TIME};
	logic [15:0] rstTab [4] = '{LOW_START_RESET, LOW_TIME_RESET, HIGH_START_RESET, HIGH_TIME_RESET};

	// short tick keeps operate times to a few dozen clocks
	directional_earth_fault_stage_logic #(.TICK_CYCLES(4)) directional_earth_fault_stage_logic_i (.*);
	def_far_side_model def_far_side_model_i (.clk_sys(clk_sys), .reset(reset), .blockReq(blockReq),
		.blockOut(external_block_inputs));

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic close_out();
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic bad();
		num_errors++;
		close_out();
	endtask

	task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chkPair(input logic [1:0] got, input logic [1:0] exp);
		chkWord({30'h0, got}, {30'h0, exp});
	endtask

	function automatic logic [31:0] nextRand(input logic [31:0] s);
		for (int i = 0; i < 16; i++)
			s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction

	// returns {low start, high start}; references double with each step of the voltage index
	function automatic logic [1:0] expStart(input logic [7:0] f, input logic cs, input int a, r, v);
		int c, u, h;
		u = int'(UREF_0) << f[7:6];
		c = (f[1] ? cs : f[2]) ? a : r;
		h = f[5] ? 400 / 5 : 400;
		return {c > int'(LOW_START_RESET) && v > u, (f[0] ? -c : c) > h && v > u};
	endfunction

	// handshake readiness is sampled mid-cycle, where it equals its value at the next edge
	task automatic axw(input logic [7:0] ad, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk_sys);
		s_axi_awaddr <= {24'h0, ad};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 50; i++)
		begin
			@(negedge clk_sys);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk_sys);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			if (tb)
			begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		bad();
	endtask

	task automatic axr(input logic [7:0] ad);
		logic ta, tr;
		@(posedge clk_sys);
		s_axi_araddr <= {24'h0, ad};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 50; i++)
		begin
			@(negedge clk_sys);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk_sys);
			if (ta)
				s_axi_arvalid <= 1'b0;
			if (tr)
			begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		bad();
	endtask

	task automatic step(input int k);
		repeat (k) @(negedge clk_sys);
	endtask

	task automatic setIn(input int ac, input int rc, input int vo);
		@(posedge clk_sys);
		activeCurrent <= 16'(ac);
		reactiveCurrent <= 16'(rc);
		residualVoltage <= 16'(vo);
	endtask

	task automatic btn(input logic st, input logic rb);
		@(posedge clk_sys);
		stepButton <= st;
		resetButton <= rb;
	endtask

	task automatic waitTrip();
		n = 0;
		while (lowStage.trip !== 1'b1)
		begin
			@(negedge clk_sys);
			n++;
			if (n > 400)
				bad();
		end
	endtask

	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hF;
		{characteristic_select_in, resetButton, stepButton, blockReq} = 6'h00;
		{activeCurrent, reactiveCurrent, residualVoltage} = 48'h0;
		num_errors = 0;
		cmp_count = 0;
		lfsr = 32'h9038;
		reset = 1'b1;
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		foreach (adrTab[i])
		begin
			axr(adrTab[i]);
			chkWord(rd, {16'h0, rstTab[i]});
		end
		axr(8'h24);
		chkPair(rsp, RESP_SLVERR);
		chkWord(rd, 32'h0);
		axw(ADDR_STATUS, 32'h1);
		chkPair(rsp, RESP_SLVERR);
		setIn(32767, 32767, 65535);
		step(60);
		chkPair(highStage, 2'h0);
		chkPair(lowStage, 2'h3);
		chkPair(lowIndicator, 2'h1);
		axr(ADDR_STATUS);
		chkWord(rd, 32'h04C);
		setIn(0, 0, 0);
		step(3);
		chkPair(lowStage, 2'h0);
		chkPair(lowIndicator, 2'h0);
		axw(ADDR_HIGH_START, 32'd400);
		chkPair(rsp, RESP_OKAY);
		for (int k = 0; k < 40; k++)
		begin
			lfsr = nextRand(lfsr);
			fsw = lfsr[7:0] & 8'hE7;
			bsw = {lfsr[11:8], 6'h00};
			a = int'(lfsr[21:12]) - 300;
			axw(ADDR_FRONT_SW, {24'h0, fsw});
			axw(ADDR_BOARD_SW, {22'h0, bsw});
			characteristic_select_in <= lfsr[22];
			lfsr = nextRand(lfsr);
			r = int'(lfsr[9:0]) - 300;
			v = int'(lfsr[20:10]);
			setIn(a, r, v);
			step(3);
			e = expStart(fsw, characteristic_select_in, a, r, v);
			chkPair({lowStage.start, highStage.start}, e);
			chkPair(reclose_initiation_outputs, {bsw[8] & e[1] | bsw[9] & e[0],
				bsw[6] & e[1] | bsw[7] & e[0]});
		end
		axw(ADDR_LOW_TIME, 32'h3);
		axw(ADDR_BOARD_SW, 32'h0);
		for (int k = 0; k < 2; k++)
		begin
			axw(ADDR_FRONT_SW, k ? 32'h14 : 32'h04);
			setIn(500, 0, 4095);
			waitTrip();
			chkPair({n >= (k ? 80 : 8), n <= (k ? 130 : 20)}, 2'h3);
			setIn(0, 0, 0);
			step(3);
			chkPair(lowStage, 2'h0);
		end
		axw(ADDR_FRONT_SW, 32'h04);
		repeat (4)
		begin
			setIn(500, 0, 4095);
			step(7);
			setIn(0, 0, 0);
			step(2);
		end
		chkPair(lowStage, 2'h0);
		axw(ADDR_FRONT_SW, 32'h0C);
		for (int j = 0; j < 3; j++)
		begin
			setIn(500, 0, 4095);
			waitTrip();
			setIn(0, 0, 0);
			step(5);
			chkPair(lowStage, 2'h1);
			if (j == 0)
			begin
				btn(1'b0, 1'b1);
				step(2);
				chkPair(lowStage, 2'h1);
				btn(1'b1, 1'b1);
			end
			else
				axw(ADDR_COMMAND, j);
			btn(1'b0, 1'b0);
			step(3);
			chkPair(lowStage, 2'h0);
		end
		axw(ADDR_FRONT_SW, 32'h04);
		axw(ADDR_HIGH_TIME, 32'h3);
		for (int k = 0; k < 3; k++)
		begin
			axw(ADDR_BOARD_SW, 32'h9 << k);
			blockReq <= 3'h1 << k;
			setIn(500, 0, 4095);
			step(40);
			chkPair({lowStage.trip, highStage.trip}, 2'h0);
			chkPair({lowStage.start, highStage.start}, 2'h3);
			@(posedge clk_sys);
			blockReq <= 3'h0;
			step(25);
			chkPair({lowStage.trip, highStage.trip}, 2'h3);
			chkPair(highIndicator, 2'h1);
			setIn(0, 0, 0);
			step(3);
		end
		axw(ADDR_IND_SW, 32'h1);
		for (int j = 0; j < 3; j++)
		begin
			setIn(500, 0, 4095);
			step(4);
			setIn(0, 0, 0);
			step(3);
			chkPair(lowIndicator, 2'h2);
			if (j == 0)
			begin
				btn(1'b0, 1'b1);
				step(3);
			end
			else
				axw(ADDR_COMMAND, j);
			btn(1'b0, 1'b0);
			step(2);
			chkPair(lowIndicator, 2'h0);
		end
		close_out();
	end
endmodule // directional_earth_fault_stage_logic_test
